/* File: rtl/shutter_consts.vh */
/*
 * Constants for the shutter, interlock and fault supervisor.
 * Assumes inclusion by bare name from the design files under rtl/.
 */
// =====================================================================
// What this block does
// R01: Shutter command high opens the shutter, low closes it.
// R02: Open status only while shutter fitted and sensed fully open.
// R03: Any system fault disables shutter and forces open status low.
// R04: Shutter fault output asserts on detection and stays latched.
// R05: Travel between positions longer than the limit is a fault.
// R06: Close commanded but closed sense absent is a fault.
// R07: Open, moving and in-between sensed states all feed fault checks.
// R08: Latched shutter fault shuts down the whole laser system.
// R09: Any temperature monitor out of range raises over-temperature fault.
// R10: Over-temperature fault is latched and shuts down laser operation.
// R11: Laser runs only while the system interlock loop is closed.
// R12: Open system interlock overrides all other permissions.
// R13: Shutter interlock gates shutter only, never system operation.
// R14: Units without shutter leave the shutter interlock unconnected.
// R15: Internal run permit flag follows the system interlock loop.
// R16: Closed status only while fitted and sensed closed, not in faults.
// R17: Modulation stays disabled until the system interlock is closed.
// R18: Faults stay latched until reset; travel limit fixed at build.
// R19: Interlock and position inputs pass two flip-flops before use.
`ifndef SHUTTER_CONSTS_VH
`define SHUTTER_CONSTS_VH

// =====================================================================
// Timing
`define CLK_FREQ_HZ        40000000
`define TRAVEL_LIMIT_MS    500
`define TRAVEL_LIMIT_CYC   ((`CLK_FREQ_HZ / 1000) * `TRAVEL_LIMIT_MS)
`define CLOSE_SETTLE_MS    500
`define CLOSE_SETTLE_CYC   ((`CLK_FREQ_HZ / 1000) * `CLOSE_SETTLE_MS)

// =====================================================================
// Reset values
`define FAULT_RST          1'h0
`define SYNC_RST           1'h0

`endif

/* File: rtl/sync_2ff.v */
/*
 * Two flip-flop level synchroniser, one bit per lane.
 * Assumes inputs are asynchronous levels; reset is synchronous.
 */
`default_nettype none
`include "shutter_consts.vh"

module sync_2ff #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    // =================================================================
    // Synchroniser chain
    // First stage is read only by the second stage
    always @(posedge clk) begin
        if (!rst_b) begin
            stage1 <= {WIDTH{`SYNC_RST}};
            stage2 <= {WIDTH{`SYNC_RST}};
        end else begin
            stage1 <= async_in; // R19
            stage2 <= stage1;   // R19
        end
    end

    assign sync_out = stage2;

endmodule
`default_nettype wire

/* File: rtl/fault_timer.v */
/*
 * Saturating watchdog: expires when arm is held LIMIT cycles.
 * Assumes arm from logic on the same clock.
 */
`default_nettype none
`include "shutter_consts.vh"

module fault_timer #(
    parameter WIDTH = 25,
    parameter LIMIT = 20000000
) (
    input  wire clk,
    input  wire rst_b,
    input  wire arm,
    output reg  expired
);

    reg [WIDTH-1:0] count;

    // =================================================================
    // Counter clears when arm drops
    always @(posedge clk) begin
        if (!rst_b || !arm) begin
            count   <= {WIDTH{1'b0}};
            expired <= 1'b0;
        end else if (count >= LIMIT[WIDTH-1:0] - 1'b1) begin
            expired <= 1'b1;
        end else begin
            count <= count + 1'b1;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/shutter_interlock_fault_monitor.v */
/*
 * Shutter control, interlock gating and latched fault supervisor.
 * Holds the input synchronisers, the shutter state machine, the
 * travel and close watchdogs, the latched shutter and temperature
 * faults, and the registered permission and status outputs.
 * Fault causes are latched until reset; no other clear exists.
 * Assumes a single clock clk, synchronous active-low reset rst_b, and
 * sensor and interlock pins asynchronous to clk. Interlock inputs are
 * high when the loop is closed to its return. Position sensors are
 * high at their end stop and low when no shutter is fitted.
 */
`default_nettype none
`include "shutter_consts.vh"

module shutter_interlock_fault_monitor #(
    parameter TEMP_CH       = 4,
    parameter TRAVEL_CYCLES = `TRAVEL_LIMIT_CYC,
    parameter SETTLE_CYCLES = `CLOSE_SETTLE_CYC,
    parameter TIMER_W       = 25
) (
    input  wire               clk,
    input  wire               rst_b,
    input  wire               shutter_cmd,
    input  wire               sys_ilk_closed,
    input  wire               shut_ilk_closed,
    input  wire               shutter_fitted,
    input  wire               sense_open,
    input  wire               sense_closed,
    input  wire [TEMP_CH-1:0] temp_out_of_range,
    output reg                shutter_drive_open,
    output reg                shutter_enable,
    output reg                shutter_open_status,
    output reg                shutter_closed_status,
    output reg                shutter_fault,
    output reg                over_temp_fault,
    output reg                run_permit,
    output reg                modulation_enable
);

    // =================================================================
    // Input synchronisation
    localparam NSYNC = 6 + TEMP_CH;

    // Packed pins and their synchronised copies
    wire [NSYNC-1:0]   pin_bus;
    wire [NSYNC-1:0]   sync_bus;

    // Synchronised pins, one name each
    wire               cmd_s;
    wire               sys_ilk_s;
    wire               shut_ilk_s;
    wire               fitted_s;
    wire               open_s;
    wire               closed_s;
    wire [TEMP_CH-1:0] temp_s;

    // Command and loops low, sensors next, temperatures on top
    assign pin_bus = {temp_out_of_range, sense_closed, sense_open,
                      shutter_fitted, shut_ilk_closed, sys_ilk_closed,
                      shutter_cmd};

    // All pins cross into clk through two stages
    sync_2ff #(
        .WIDTH    (NSYNC)
    ) u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in (pin_bus),
        .sync_out (sync_bus)
    ); // R19

    // Unpack the synchronised copies
    assign cmd_s      = sync_bus[0];
    assign sys_ilk_s  = sync_bus[1];
    assign shut_ilk_s = sync_bus[2];
    assign fitted_s   = sync_bus[3];
    assign open_s     = sync_bus[4];
    assign closed_s   = sync_bus[5];
    assign temp_s     = sync_bus[NSYNC-1:6];

    // =================================================================
    // Sensed shutter position classes
    // Decoded shutter positions
    wire pos_open;
    wire pos_closed;
    wire pos_between;
    wire pos_invalid;

    // In-between covers moving or stuck; both sensed is invalid
    assign pos_open    = open_s & ~closed_s;          // R07
    assign pos_closed  = closed_s & ~open_s;          // R07
    assign pos_between = ~open_s & ~closed_s;         // R07
    assign pos_invalid = open_s & closed_s;           // R07

    // =================================================================
    // Shutter state machine
    // One-hot shutter states
    localparam ST_IDLE    = 5'h01; // Disabled, drive released
    localparam ST_CLOSED  = 5'h02; // Parked at the closed stop
    localparam ST_OPENING = 5'h04; // Moving towards open
    localparam ST_OPEN    = 5'h08; // Parked at the open stop
    localparam ST_CLOSING = 5'h10; // Moving towards closed

    // State, gating and fault summary
    reg  [4:0] state;
    reg  [4:0] next_state;
    wire       shut_ready;
    wire       active;
    wire       system_fault;

    // Any latched fault is a system fault
    assign system_fault = shutter_fault | over_temp_fault;       // R03

    // Shutter works only when fitted, its loop closed and no fault
    assign shut_ready = fitted_s & shut_ilk_s;                   // R13
    assign active     = shut_ready & ~system_fault;              // R03 R13

    // Next state from command and sensed position
    always @* begin
        // Hold unless a transition below applies
        next_state = state;
        case (state)
            // Wait until the shutter becomes usable
            ST_IDLE: begin
                if (active) begin
                    next_state = cmd_s ? ST_OPENING : ST_CLOSING; // R01
                end
            end

            // Parked closed until an open command
            ST_CLOSED: begin
                if (!active) begin
                    next_state = ST_IDLE;
                end else if (cmd_s) begin
                    next_state = ST_OPENING;                      // R01
                end
            end

            // Moving open; reverse at once on a close command
            ST_OPENING: begin
                if (!active) begin
                    next_state = ST_IDLE;
                end else if (!cmd_s) begin
                    next_state = ST_CLOSING;                      // R01
                end else if (pos_open) begin
                    next_state = ST_OPEN;
                end
            end

            // Parked open until a close command
            ST_OPEN: begin
                if (!active) begin
                    next_state = ST_IDLE;
                end else if (!cmd_s) begin
                    next_state = ST_CLOSING;                      // R01
                end
            end

            // Moving closed; reverse at once on an open command
            ST_CLOSING: begin
                if (!active) begin
                    next_state = ST_IDLE;
                end else if (cmd_s) begin
                    next_state = ST_OPENING;                      // R01
                end else if (pos_closed) begin
                    next_state = ST_CLOSED;
                end
            end

            // Unused codes fall back to idle
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // =================================================================
    // Fault timers
    // Watchdog arms and their expiry flags
    wire travelling;
    wire close_mismatch;
    wire travel_expired;
    wire close_expired;

    // Travel time runs while moving in either direction
    assign travelling = (state == ST_OPENING) |
                        (state == ST_CLOSING);                   // R05

    // Close requested but the closed sense is missing
    assign close_mismatch = active & ~cmd_s & ~pos_closed;       // R06

    // Travel watchdog, limit fixed when the block is built
    fault_timer #(
        .WIDTH   (TIMER_W),
        .LIMIT   (TRAVEL_CYCLES)
    ) u_travel (
        .clk     (clk),
        .rst_b   (rst_b),
        .arm     (travelling),
        .expired (travel_expired)
    ); // R05

    // Close watchdog, allows the vane time to reach its stop
    fault_timer #(
        .WIDTH   (TIMER_W),
        .LIMIT   (SETTLE_CYCLES)
    ) u_close (
        .clk     (clk),
        .rst_b   (rst_b),
        .arm     (close_mismatch),
        .expired (close_expired)
    ); // R06

    // Shutter that leaves the open stop without a command
    wire left_open;
    wire drift_fault;

    assign left_open = (state == ST_OPEN) & ~pos_open;           // R07

    // Leaving open unbidden, or both stops sensed, is a fault
    assign drift_fault = active & (left_open | pos_invalid);     // R07

    // Causes that latch the shutter and temperature faults
    wire shut_fault_event;
    wire temp_hot;

    assign shut_fault_event = travel_expired | close_expired |
                              drift_fault;                       // R04
    assign temp_hot = |temp_s;                                   // R09

    // =================================================================
    // Latched faults, cleared only by reset
    // Shutter fault holds once any cause is seen
    always @(posedge clk) begin
        if (!rst_b) begin
            shutter_fault <= `FAULT_RST;
        end else if (shut_fault_event) begin
            shutter_fault <= 1'h1;                               // R04
        end
    end // R18

    // Temperature fault holds once any channel is out of range
    always @(posedge clk) begin
        if (!rst_b) begin
            over_temp_fault <= `FAULT_RST;
        end else if (temp_hot) begin
            over_temp_fault <= 1'h1;                             // R09 R10
        end
    end // R18

    // =================================================================
    // Permissions and outputs
    wire next_run_permit;

    // System loop overrides all; faults also stop the laser
    assign next_run_permit = sys_ilk_s & ~system_fault;   // R12 R08 R10

    // Laser permissions follow the system loop and drop on any latched fault
    always @(posedge clk) begin
        if (!rst_b) begin
            run_permit        <= 1'h0;
            modulation_enable <= 1'h0;
        end else begin
            run_permit        <= next_run_permit;                // R15 R11
            modulation_enable <= next_run_permit;                // R17
        end
    end

    // Shutter power and drive, released when not usable
    always @(posedge clk) begin
        if (!rst_b) begin
            shutter_enable     <= 1'h0;
            shutter_drive_open <= 1'h0;
        end else begin
            shutter_enable     <= active;                        // R03 R13
            shutter_drive_open <= active & cmd_s;                // R01
        end
    end

    // Position status, withheld while the shutter is disabled
    always @(posedge clk) begin
        if (!rst_b) begin
            shutter_open_status   <= 1'h0;
            shutter_closed_status <= 1'h0;
        end else begin
            shutter_open_status   <= active & pos_open;          // R02 R03
            shutter_closed_status <= active & pos_closed;        // R16
        end
    end

endmodule
`default_nettype wire

/* File: verification/shutter_checker.sv */
/* Port assertions for the shutter supervisor.
   Assumes a bind to the design top; inputs reach outputs in 3 edges. */
`default_nettype none
module shutter_checker #(
    parameter TEMP_CH = 4
) (
    input wire logic               clk,
    input wire logic               rst_b,
    input wire logic               shutter_cmd,
    input wire logic               sys_ilk_closed,
    input wire logic               shut_ilk_closed,
    input wire logic               shutter_fitted,
    input wire logic               sense_open,
    input wire logic               sense_closed,
    input wire logic [TEMP_CH-1:0] temp_out_of_range,
    input wire logic               shutter_drive_open,
    input wire logic               shutter_enable,
    input wire logic               shutter_open_status,
    input wire logic               shutter_closed_status,
    input wire logic               shutter_fault,
    input wire logic               over_temp_fault,
    input wire logic               run_permit,
    input wire logic               modulation_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // =====================================================
    // Sequences
    sequence s_fault;
        shutter_fault || over_temp_fault;
    endsequence
    sequence s_temp_hit;
        (rst_b && |temp_out_of_range) ##1 rst_b ##1 rst_b;
    endsequence
    // =====================================================
    // Assertions
    a_loop_gates_permit: assert property (!$past(sys_ilk_closed, 3) |-> !run_permit)
        else $error("run permit without system loop");
    a_mod_tracks_permit: assert property (modulation_enable == run_permit)
        else $error("modulation differs from permit");
    a_fault_stops_run: assert property (s_fault |=> !run_permit)
        else $error("run permit during fault");
    a_fault_stops_shutter: assert property (s_fault |=> !shutter_enable
        && !shutter_drive_open && !shutter_open_status
        && !shutter_closed_status)
        else $error("shutter active during fault");
    a_shut_fault_held: assert property (shutter_fault |=> shutter_fault)
        else $error("shutter fault released");
    a_temp_fault_held: assert property (over_temp_fault |=> $stable(over_temp_fault))
        else $error("temperature fault released");
    a_temp_detect: assert property (s_temp_hit |=> over_temp_fault)
        else $error("temperature fault missed");
    a_open_needs_sense: assert property (shutter_open_status
        |-> $past(sense_open, 3) && $past(shutter_fitted, 3))
        else $error("open status without open sense");
    a_closed_needs_sense: assert property (shutter_closed_status
        |-> $past(sense_closed, 3) && $past(shutter_fitted, 3))
        else $error("closed status without closed sense");
    a_shut_loop_gates: assert property (!$past(shut_ilk_closed, 3)
        && !$past(shut_ilk_closed, 4) |-> !shutter_enable)
        else $error("shutter enabled with loop open");
    a_drive_needs_cmd: assert property (shutter_drive_open
        |-> $past(shutter_cmd, 3) || $past(shutter_cmd, 4))
        else $error("drive open without command");
endmodule
bind shutter_interlock_fault_monitor shutter_checker #(.TEMP_CH(TEMP_CH)) chk (
    .clk(clk), .rst_b(rst_b), .shutter_cmd(shutter_cmd),
    .sys_ilk_closed(sys_ilk_closed), .shut_ilk_closed(shut_ilk_closed),
    .shutter_fitted(shutter_fitted), .sense_open(sense_open),
    .sense_closed(sense_closed), .temp_out_of_range(temp_out_of_range),
    .shutter_drive_open(shutter_drive_open),
    .shutter_enable(shutter_enable),
    .shutter_open_status(shutter_open_status),
    .shutter_closed_status(shutter_closed_status),
    .shutter_fault(shutter_fault), .over_temp_fault(over_temp_fault),
    .run_permit(run_permit), .modulation_enable(modulation_enable));
`default_nettype wire

/* File: verification/shutter_mech.sv */
/* Shutter mechanism and shutter loop of the outside controller.
   Assumes drive inputs from the design; sense lines pulled low. */
`default_nettype none
module shutter_mech #(
    parameter TRAVEL = 6
) (
    input  wire logic clk,
    input  wire logic drive_open,
    input  wire logic powered,
    input  wire logic fitted,
    input  wire logic stuck,
    input  wire logic slow,
    input  wire logic loop_ok,
    output logic      sense_open,
    output logic      sense_closed,
    output logic      shut_ilk_closed
);
    timeunit 1ns;
    timeprecision 100ps;
    int pos = 0;
    logic tick = 1'h0;
    // Vane steps toward the driven end, half speed when slow
    always @(negedge clk) begin
        tick <= ~tick;
        if (powered && !stuck && (!slow || tick)) begin
            if (drive_open && pos < TRAVEL) pos <= pos + 1;
            if (!drive_open && pos > 0) pos <= pos - 1;
        end
    end
    // Sensors read low when no shutter is fitted
    assign sense_open = fitted && pos == TRAVEL;
    assign sense_closed = fitted && pos == 0;
    assign shut_ilk_closed = fitted && loop_ok;
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
/* Self-checking bench for the shutter supervisor.
   Assumes shutter_mech as far side and the bound checker. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0, rst_b = 1'h0, shutter_cmd = 1'h0;
    logic sys_ilk_closed = 1'h1, shutter_fitted = 1'h1, stuck = 1'h0;
    logic slow = 1'h0, loop_ok = 1'h1;
    logic [3:0] temp_out_of_range = 4'h0;
    logic sense_open, sense_closed, shut_ilk_closed, shutter_drive_open;
    logic shutter_enable, shutter_open_status, shutter_closed_status;
    logic shutter_fault, over_temp_fault, run_permit, modulation_enable;
    int miscompares = 0, tests_run = 0;
    // =====================================================
    // Clock and instances
    always #12.5 clk = ~clk;
    shutter_interlock_fault_monitor #(.TEMP_CH(4), .TRAVEL_CYCLES(30),
        .SETTLE_CYCLES(20), .TIMER_W(25)) DUT (
        .clk(clk), .rst_b(rst_b), .shutter_cmd(shutter_cmd),
        .sys_ilk_closed(sys_ilk_closed), .shut_ilk_closed(shut_ilk_closed),
        .shutter_fitted(shutter_fitted), .sense_open(sense_open),
        .sense_closed(sense_closed), .temp_out_of_range(temp_out_of_range),
        .shutter_drive_open(shutter_drive_open),
        .shutter_enable(shutter_enable),
        .shutter_open_status(shutter_open_status),
        .shutter_closed_status(shutter_closed_status),
        .shutter_fault(shutter_fault), .over_temp_fault(over_temp_fault),
        .run_permit(run_permit), .modulation_enable(modulation_enable));
    shutter_mech #(.TRAVEL(6)) mech (.clk(clk),
        .drive_open(shutter_drive_open), .powered(shutter_enable),
        .fitted(shutter_fitted), .stuck(stuck), .slow(slow),
        .loop_ok(loop_ok), .sense_open(sense_open),
        .sense_closed(sense_closed), .shut_ilk_closed(shut_ilk_closed));
    // =====================================================
    // Tasks
    task idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task check(input string what, input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %b seen %b", what, exp, seen);
            miscompares++;
        end
    endtask
    task automatic await(ref logic s, input int lim);
        for (int i = 0; i < lim && s !== 1'h1; i++) idle(1);
    endtask
    task restart;
        rst_b = 1'h0;
        shutter_cmd = 1'h0;
        stuck = 1'h0;
        temp_out_of_range = 4'h0;
        idle(10);
        check("fault in reset", shutter_fault, 1'h0);
        rst_b = 1'h1;
        idle(30);
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // =====================================================
    // Watchdog
    initial begin
        idle(20000);
        miscompares++;
        conclude;
    end
    // =====================================================
    // Tests
    initial begin
        restart;
        check("permit", run_permit, 1'h1);
        check("modulation", modulation_enable, 1'h1);
        check("closed status", shutter_closed_status, 1'h1);
        shutter_cmd = 1'h1;
        await(shutter_open_status, 40);
        check("open status", shutter_open_status, 1'h1);
        check("drive open", shutter_drive_open, 1'h1);
        check("closed status", shutter_closed_status, 1'h0);
        loop_ok = 1'h0;
        idle(6);
        check("shutter enable", shutter_enable, 1'h0);
        check("permit", run_permit, 1'h1);
        loop_ok = 1'h1;
        slow = 1'h1;
        shutter_cmd = 1'h0;
        await(shutter_closed_status, 60);
        check("closed status", shutter_closed_status, 1'h1);
        check("fault", shutter_fault, 1'h0);
        slow = 1'h0;
        sys_ilk_closed = 1'h0;
        idle(4);
        check("permit", run_permit, 1'h0);
        check("modulation", modulation_enable, 1'h0);
        sys_ilk_closed = 1'h1;
        idle(4);
        check("permit", run_permit, 1'h1);
        $display("test normal done");
        stuck = 1'h1;
        shutter_cmd = 1'h1;
        await(shutter_fault, 80);
        check("fault", shutter_fault, 1'h1);
        idle(2);
        check("permit", run_permit, 1'h0);
        check("closed status", shutter_closed_status, 1'h0);
        check("drive open", shutter_drive_open, 1'h0);
        stuck = 1'h0;
        shutter_cmd = 1'h0;
        idle(40);
        check("fault", shutter_fault, 1'h1);
        $display("test travel done");
        restart;
        shutter_cmd = 1'h1;
        await(shutter_open_status, 40);
        stuck = 1'h1;
        shutter_cmd = 1'h0;
        idle(15);
        check("fault early", shutter_fault, 1'h0);
        idle(10);
        check("fault", shutter_fault, 1'h1);
        $display("test close done");
        for (int ch = 0; ch < 4; ch++) begin
            restart;
            temp_out_of_range[ch] = 1'h1;
            idle(4);
            check("temp fault", over_temp_fault, 1'h1);
            temp_out_of_range = 4'h0;
            idle(4);
            check("temp fault", over_temp_fault, 1'h1);
            check("permit", run_permit, 1'h0);
        end
        $display("test temperature done");
        shutter_fitted = 1'h0;
        restart;
        shutter_cmd = 1'h1;
        idle(30);
        check("open status", shutter_open_status, 1'h0);
        check("closed status", shutter_closed_status, 1'h0);
        check("drive open", shutter_drive_open, 1'h0);
        $display("test unfitted done");
        conclude;
    end
endmodule
`default_nettype wire
